// >>> inc/sme_pkg.sv
// Purpose: Shared constants and types of the serial master controller
// Assumes: One packed config struct per chip select line
// Notes: Reset values of the control state live here
package sme_pkg;
    localparam int DEF_NCS = 4;
    localparam int DEF_BITS = 8;
    // Field widths and positions of a chip select config word
    localparam int DIV_W = 8;
    localparam int CFG_KEEP_POS = 0;
    localparam int CFG_PHASE_POS = 1;
    localparam int CFG_POL_POS = 2;
    localparam int CFG_DIV_POS = 3;
    // Divisor value that provokes the extra clock pulse
    localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
    // Edges added by the extra pulse
    localparam int EXTRA_EDGES = 2;
    // Reset values
    localparam logic RST_ENABLED = 1'b0;
    localparam logic RST_TX_EMPTY = 1'b1;
    localparam logic RST_FAULT = 1'b0;
    localparam logic RST_CS_N = 1'b1;
    // Pin sync stages
    localparam int SYNC_STAGES = 2;

    typedef struct packed {
        logic [DIV_W-1:0] serial_clock_divisor;
        logic clock_polarity;
        logic clock_phase_select;
        logic keep_select_after_transfer;
    } sme_cs_cfg_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_HOLD
    } sme_state_e;
endpackage

// >>> verilog/sme_buf.sv
// Purpose: Small valid/ready buffer between data register and shifter
// Assumes: DEPTH is a power of two
// Notes: Flush empties it in one cycle
`timescale 1ns/1ps
module sme_buf #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    assign in_ready = (count_ff != (AW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data = mem[rd_ptr_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else if (flush) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// >>> verilog/sme_master.sv
// Purpose: Serial master controller with its known silicon defects kept
// Assumes: Control bits arrive as plain ports on clk; pins are async
// Notes: Slave mode only receives; enable/disable are one-cycle pulses
`timescale 1ns/1ps
module sme_master #(
    parameter int NCS = sme_pkg::DEF_NCS,
    parameter int BITS = sme_pkg::DEF_BITS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control register pulses and mode bits
    input wire logic enable_cmd,
    input wire logic disable_cmd,
    input wire logic software_reset_bit,
    input wire logic master_mode,
    input wire logic mode_fault_disable,
    input wire logic [$clog2(NCS)-1:0] cs_sel,
    input wire sme_pkg::sme_cs_cfg_s [NCS-1:0] chip_select_config,
    // Transmit data register write port, processor or DMA
    input wire logic data_wr,
    input wire logic [BITS-1:0] transmit_data_register,
    // Status
    output logic transmit_empty_flag,
    output logic dma_tx_req,
    output logic enabled,
    output logic mode_fault,
    output logic [BITS-1:0] rx_data,
    output logic rx_valid,
    // Serial pins
    output logic sck_o,
    output logic mosi_o,
    output logic [NCS-1:0] cs_n_o,
    input wire logic miso_i,
    input wire logic sck_i,
    input wire logic ss_n_i,
    input wire logic mosi_i,
    input wire logic fault_n_i
);
    localparam int EW = $clog2(2*BITS + sme_pkg::EXTRA_EDGES + 1);
    localparam int BW = $clog2(BITS + 1);
    localparam logic [EW-1:0] DATA_EDGES = EW'(2*BITS);

    sme_pkg::sme_state_e state_ff;
    sme_pkg::sme_cs_cfg_s cur_ff;
    logic en_ff, empty_ff, fault_ff, sck_ff, sck_q_ff, mosi_ff, extra_ff;
    logic [NCS-1:0] cs_n_ff;
    logic [BITS-1:0] tx_ff, rx_ff, rxo_ff;
    logic rxv_ff;
    logic [sme_pkg::DIV_W-1:0] div_cnt_ff;
    logic [EW-1:0] ecnt_ff, hcnt_ff;
    logic [BW-1:0] scnt_ff;
    logic [4:0] s1_ff, s2_ff;
    logic sck_s_q_ff;
    logic act_q_ff;
    logic buf_in_ready, buf_out_valid, buf_pop, push;
    logic [BITS-1:0] buf_data;
    logic stall, start, tick, last, leading, sample_e, extra_now;
    logic [sme_pkg::DIV_W-1:0] div_eff;
    logic [EW-1:0] total;
    logic any_one, any_other;

    // Pins pass two flops; first stage feeds only the second
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_ff <= 5'h1A;
            s2_ff <= 5'h1A;
        end else begin
            s1_ff <= {fault_n_i, ss_n_i, sck_i, mosi_i, miso_i};
            s2_ff <= s1_ff;
        end
    end

    // Dropped when disabled or when the flag is low
    assign push = en_ff && empty_ff && data_wr;

    sme_buf #(.W(BITS), .DEPTH(2)) u_buf (
        .clk(clk),
        .reset_n(reset_n),
        .flush(software_reset_bit),
        .in_valid(push),
        .in_ready(buf_in_ready),
        .in_data(transmit_data_register),
        .out_valid(buf_out_valid),
        .out_ready(buf_pop),
        .out_data(buf_data)
    );

    // Mixed divisor check over every chip select
    always_comb begin
        any_one = 1'b0;
        any_other = 1'b0;
        for (int i = 0; i < NCS; i++) begin
            if (chip_select_config[i].serial_clock_divisor == sme_pkg::DIV_ONE)
                any_one = 1'b1;
            else
                any_other = 1'b1;
        end
    end

    assign extra_now = any_one && any_other
        && chip_select_config[cs_sel].clock_polarity
        && !chip_select_config[cs_sel].clock_phase_select;
    assign stall = chip_select_config[0].keep_select_after_transfer
        && !mode_fault_disable;
    // Waiting for the line to settle keeps back-to-back frames distinct
    assign start = en_ff && master_mode && buf_out_valid && !stall
        && (sck_ff == sck_q_ff)
        && (state_ff == sme_pkg::ST_IDLE
            || (state_ff == sme_pkg::ST_HOLD
                && cur_ff == chip_select_config[cs_sel]));
    assign buf_pop = start;
    assign div_eff = (cur_ff.serial_clock_divisor == '0)
        ? sme_pkg::DIV_ONE : cur_ff.serial_clock_divisor;
    assign tick = (state_ff == sme_pkg::ST_SHIFT)
        && (div_cnt_ff == div_eff - 1'b1);
    assign total = DATA_EDGES
        + (extra_ff ? EW'(sme_pkg::EXTRA_EDGES) : '0);
    assign last = tick && (ecnt_ff == total - 1'b1);
    assign leading = !ecnt_ff[0];
    assign sample_e = cur_ff.clock_phase_select ? leading : !leading;

    // Enable, disable, software reset and mode fault
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            en_ff <= sme_pkg::RST_ENABLED;
            fault_ff <= sme_pkg::RST_FAULT;
        end else if (software_reset_bit) begin
            en_ff <= sme_pkg::RST_ENABLED;
            fault_ff <= sme_pkg::RST_FAULT;
        end else if (master_mode && en_ff && !mode_fault_disable
                     && !s2_ff[4]) begin
            en_ff <= 1'b0;
            fault_ff <= 1'b1;
        end else if (enable_cmd) begin
            en_ff <= 1'b1;
        end else if (disable_cmd && master_mode) begin
            en_ff <= 1'b0;
        end
    end

    // Flag holds while disabled, so a DMA keeps pushing into nothing
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            empty_ff <= sme_pkg::RST_TX_EMPTY;
        end else if (software_reset_bit) begin
            empty_ff <= sme_pkg::RST_TX_EMPTY;
        end else if (en_ff) begin
            if (push)
                empty_ff <= 1'b0;
            else if (buf_in_ready)
                empty_ff <= 1'b1;
        end
    end

    // Master sequencer and clock divider
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= sme_pkg::ST_IDLE;
            cur_ff <= '0;
            extra_ff <= 1'b0;
            div_cnt_ff <= '0;
            ecnt_ff <= '0;
            sck_ff <= 1'b0;
            mosi_ff <= 1'b0;
            tx_ff <= '0;
            rx_ff <= '0;
            cs_n_ff <= {NCS{sme_pkg::RST_CS_N}};
        end else if (software_reset_bit || !en_ff) begin
            state_ff <= sme_pkg::ST_IDLE;
            cs_n_ff <= {NCS{sme_pkg::RST_CS_N}};
            sck_ff <= chip_select_config[cs_sel].clock_polarity;
        end else begin
            case (state_ff)
                sme_pkg::ST_IDLE, sme_pkg::ST_HOLD: begin
                    if (start) begin
                        state_ff <= sme_pkg::ST_SHIFT;
                        cur_ff <= chip_select_config[cs_sel];
                        extra_ff <= extra_now;
                        div_cnt_ff <= '0;
                        ecnt_ff <= '0;
                        cs_n_ff <= ~(NCS'(1) << cs_sel);
                        sck_ff <= chip_select_config[cs_sel].clock_polarity;
                        if (chip_select_config[cs_sel]
                                .clock_phase_select) begin
                            mosi_ff <= buf_data[BITS-1];
                            tx_ff <= buf_data << 1;
                        end else begin
                            tx_ff <= buf_data;
                        end
                    end else if (state_ff == sme_pkg::ST_IDLE) begin
                        sck_ff <= chip_select_config[cs_sel].clock_polarity;
                    end else if (cur_ff != chip_select_config[cs_sel]) begin
                        state_ff <= sme_pkg::ST_IDLE;
                        cs_n_ff <= {NCS{sme_pkg::RST_CS_N}};
                    end
                end
                sme_pkg::ST_SHIFT: begin
                    div_cnt_ff <= tick ? '0 : div_cnt_ff + 1'b1;
                    if (tick) begin
                        sck_ff <= ~sck_ff;
                        ecnt_ff <= ecnt_ff + 1'b1;
                        if (ecnt_ff < DATA_EDGES) begin
                            if (sample_e) begin
                                rx_ff <= {rx_ff[BITS-2:0], s2_ff[0]};
                            end else begin
                                mosi_ff <= tx_ff[BITS-1];
                                tx_ff <= tx_ff << 1;
                            end
                        end
                    end
                    if (last) begin
                        if (cur_ff.keep_select_after_transfer) begin
                            state_ff <= sme_pkg::ST_HOLD;
                        end else begin
                            state_ff <= sme_pkg::ST_IDLE;
                            cs_n_ff <= {NCS{sme_pkg::RST_CS_N}};
                        end
                    end
                end
                default: begin
                    state_ff <= sme_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Slave receive on rising edges of the synced link clock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sck_s_q_ff <= 1'b0;
            scnt_ff <= '0;
            rxo_ff <= '0;
            rxv_ff <= 1'b0;
        end else begin
            sck_s_q_ff <= s2_ff[2];
            rxv_ff <= 1'b0;
            if (software_reset_bit || master_mode || s2_ff[3]) begin
                scnt_ff <= '0;
            end else if (en_ff && s2_ff[2] && !sck_s_q_ff) begin
                rxo_ff <= {rxo_ff[BITS-2:0], s2_ff[1]};
                if (scnt_ff == BW'(BITS - 1)) begin
                    scnt_ff <= '0;
                    rxv_ff <= 1'b1;
                end else begin
                    scnt_ff <= scnt_ff + 1'b1;
                end
            end
            if (master_mode && last) begin
                rxo_ff <= rx_ff;
                rxv_ff <= 1'b1;
            end
        end
    end

    // Edge counter on the pin clock for the checks; its delayed clock copy also gates start
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sck_q_ff <= 1'b0;
            act_q_ff <= 1'b0;
            hcnt_ff <= '0;
        end else begin
            sck_q_ff <= sck_ff;
            // Last edge lands as the state leaves shift, so look one back
            act_q_ff <= (state_ff == sme_pkg::ST_SHIFT);
            if (start)
                hcnt_ff <= '0;
            else if (sck_ff != sck_q_ff && act_q_ff)
                hcnt_ff <= hcnt_ff + 1'b1;
        end
    end

    assign transmit_empty_flag = empty_ff;
    assign dma_tx_req = empty_ff;
    assign enabled = en_ff;
    assign mode_fault = fault_ff;
    assign rx_data = rxo_ff;
    assign rx_valid = rxv_ff;
    assign sck_o = sck_ff;
    assign mosi_o = mosi_ff;
    assign cs_n_o = cs_n_ff;

    a_extra_pulse: assert property (
        @(posedge clk) disable iff (!reset_n)
        (last && en_ff && !software_reset_bit) |=> ##1
        (hcnt_ff == DATA_EDGES
            + (extra_ff ? EW'(sme_pkg::EXTRA_EDGES) : '0)))
        else $error("clock pulse count wrong for this frame");
    a_stall_hold: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_ff == sme_pkg::ST_IDLE && stall) |=>
        state_ff == sme_pkg::ST_IDLE)
        else $error("transfer began despite keep-select stall");
    a_flag_frozen: assert property (
        @(posedge clk) disable iff (!reset_n)
        (!en_ff && !software_reset_bit) |=> $stable(empty_ff))
        else $error("empty flag moved while disabled");
    a_write_drop: assert property (
        @(posedge clk) disable iff (!reset_n)
        (!en_ff && data_wr && !software_reset_bit) |->
        !push ##1 $stable(empty_ff))
        else $error("write taken while disabled");
    a_dma_keeps: assert property (
        @(posedge clk) disable iff (!reset_n)
        (!en_ff && dma_tx_req && !software_reset_bit && !enable_cmd)
        |=> dma_tx_req)
        else $error("DMA request dropped while disabled");
    a_slave_disable: assert property (
        @(posedge clk) disable iff (!reset_n)
        (!master_mode && en_ff && disable_cmd && !software_reset_bit)
        |=> en_ff)
        else $error("slave mode honoured disable");
    a_flag_clear: assert property (
        @(posedge clk) disable iff (!reset_n)
        (en_ff && empty_ff && data_wr && !software_reset_bit) |=>
        (!empty_ff && (!en_ff || !buf_in_ready))
            or (!empty_ff ##1 empty_ff))
        else $error("empty flag not cleared then set");
endmodule

// >>> verification/sme_slave_model.sv
// Purpose: Behavioural serial slave on the select lines of the master
// Assumes: Sampled on the system clock; half periods of one cycle or more
// Notes: A released data line toggles each cycle, never holds its value
`timescale 1ns/1ps
module sme_slave_model (
    // Clock and control
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clr,
    // Frame settings and reply word
    input wire logic pol,
    input wire logic phase,
    input wire logic [7:0] reply,
    // Serial pins
    input wire logic sck,
    input wire logic mosi,
    input wire logic [3:0] cs_n,
    output logic miso,
    // Observations
    output int edges,
    output logic [7:0] got
);
    logic sck_q, sel_q, lead, smp;
    int nb;
    assign lead = (sck != sck_q) && (sck != pol);
    assign smp = phase ? lead : (sck != sck_q) && (sck == pol);
    always @(posedge clk) begin
        sck_q <= sck;
        sel_q <= !(&cs_n);
        if (!reset_n || clr) begin
            edges <= 0;
        end else if (sel_q && sck != sck_q) begin
            edges <= edges + 1;
            if (smp) begin
                got <= {got[6:0], mosi};
                nb <= nb + 1;
            end else if (nb < 8) begin
                miso <= reply[7 - nb];
            end
        end
        // Start of select is not counted: it loads the first reply bit and clears the bit count
        if (!sel_q && !(&cs_n)) begin
            miso <= reply[7];
            nb <= 0;
        end else if (!sel_q) begin
            miso <= ~miso;
        end
    end
endmodule

// >>> verification/sme_master_tb.sv
// Purpose: Self-checking bench of the serial master controller
// Assumes: Four select lines, eight bit words, slave model on the pins
// Notes: Inputs move on the falling clock edge; the link clock is async
`timescale 1ns/1ps
`define CHK(a, b, m) begin checks_done++; if ((a) !== (b)) begin \
    fail_count++; $display("BAD %0t %s", $time, m); end end
module sme_master_tb;
    logic clk, reset_n, enable_cmd, disable_cmd, software_reset_bit;
    logic master_mode, mode_fault_disable, data_wr, clr;
    logic miso_i, sck_i, ss_n_i, mosi_i, fault_n_i;
    logic flag, dma_tx_req, enabled, mode_fault, rx_valid, sck_o, mosi_o;
    logic [1:0] cs_sel;
    logic [3:0] cs_n_o;
    logic [7:0] tx, rx_data, got;
    sme_pkg::sme_cs_cfg_s [3:0] cfg;
    int edges, e_ok, cycles, fail_count, checks_done;

    sme_master sme_master_inst (
        .clk(clk), .reset_n(reset_n), .enable_cmd(enable_cmd),
        .disable_cmd(disable_cmd), .software_reset_bit(software_reset_bit),
        .master_mode(master_mode), .mode_fault_disable(mode_fault_disable),
        .cs_sel(cs_sel), .chip_select_config(cfg), .data_wr(data_wr),
        .transmit_data_register(tx), .transmit_empty_flag(flag),
        .dma_tx_req(dma_tx_req), .enabled(enabled), .mode_fault(mode_fault),
        .rx_data(rx_data), .rx_valid(rx_valid), .sck_o(sck_o),
        .mosi_o(mosi_o), .cs_n_o(cs_n_o), .miso_i(miso_i), .sck_i(sck_i),
        .ss_n_i(ss_n_i), .mosi_i(mosi_i), .fault_n_i(fault_n_i)
    );
    sme_slave_model sme_slave_model_inst (
        .clk(clk), .reset_n(reset_n), .clr(clr),
        .pol(cfg[cs_sel].clock_polarity),
        .phase(cfg[cs_sel].clock_phase_select), .reply(8'h3C),
        .sck(sck_o), .mosi(mosi_o), .cs_n(cs_n_o), .miso(miso_i),
        .edges(edges), .got(got)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Longest path is a few thousand cycles; this leaves wide margin
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fail_count++;
            print_verdict;
        end
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask
    task automatic wr(input logic [7:0] d, input logic exp);
        @(negedge clk);
        tx = d;
        data_wr = 1'b1;
        @(negedge clk);
        data_wr = 1'b0;
        `CHK(flag, exp, "empty flag after write")
    endtask
    task automatic clear_model;
        @(negedge clk);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
    endtask
    task automatic wait_rx(input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(negedge clk);
            if (rx_valid === 1'b1) break;
        end
        `CHK(i < lim, 1'b1, "no word came back")
    endtask
    task automatic set_cfg(input logic [7:0] d, input logic p, input logic h);
        for (int i = 0; i < 4; i++) begin
            cfg[i] = {d, p, h, 1'b0};
        end
    endtask
    task automatic frame(input logic [7:0] d);
        clear_model;
        wr(d, 1'b0);
        @(negedge clk);
        `CHK(flag, 1'b1, "flag back with room")
        wait_rx(4000);
        repeat (4) @(negedge clk);
    endtask

    task automatic t_reset;
        `CHK(flag, 1'b1, "flag reset value")
        `CHK(enabled, 1'b0, "enabled reset value")
        `CHK(cs_n_o, 4'hF, "selects idle")
        `CHK(mode_fault, 1'b0, "no fault")
        $display("done reset");
    endtask
    task automatic t_frame;
        set_cfg(8'h04, 1'b0, 1'b1);
        cs_sel = 2'h1;
        pulse(enable_cmd);
        `CHK(enabled, 1'b1, "enable")
        frame(8'hA5);
        `CHK(got, 8'hA5, "mosi word")
        `CHK(rx_data, 8'h3C, "miso word")
        `CHK(edges, 2 * 8, "edge count")
        $display("done frame");
    endtask
    task automatic t_extra;
        set_cfg(8'h01, 1'b1, 1'b0);
        frame(8'h5A);
        e_ok = edges;
        cfg[1].serial_clock_divisor = 8'h02;
        frame(8'h5A);
        `CHK(edges - e_ok, sme_pkg::EXTRA_EDGES, "extra pulse")
        $display("done extra pulse");
    endtask
    task automatic t_stall;
        set_cfg(8'h04, 1'b0, 1'b1);
        cfg[0].keep_select_after_transfer = 1'b1;
        mode_fault_disable = 1'b0;
        clear_model;
        wr(8'hC3, 1'b0);
        repeat (300) @(negedge clk);
        `CHK(cs_n_o, 4'hF, "stalled, no select")
        `CHK(edges, 0, "stalled, no clock")
        mode_fault_disable = 1'b1;
        wait_rx(4000);
        repeat (4) @(negedge clk);
        `CHK(got, 8'hC3, "word after fault off")
        cfg[0].keep_select_after_transfer = 1'b0;
        repeat (20) @(negedge clk);
        $display("done stall");
    endtask
    task automatic t_disable;
        int n, k;
        pulse(disable_cmd);
        `CHK(enabled, 1'b0, "disable")
        `CHK(flag, 1'b1, "flag kept")
        clear_model;
        for (int i = 0; i < 4; i++) begin
            wr(8'h10 + 8'(i), 1'b1);
            `CHK(dma_tx_req, 1'b1, "dma keeps asking")
        end
        repeat (200) @(negedge clk);
        `CHK(edges, 0, "dropped words not sent")
        // Resume in the safe order: controller first, then the DMA side
        pulse(enable_cmd);
        set_cfg(8'h10, 1'b0, 1'b1);
        cs_sel = 2'h3;
        n = 0;
        for (int i = 0; i < 12; i++) begin
            if (flag === 1'b1) begin
                wr(8'h20 + 8'(n), 1'b0);
                n++;
            end else begin
                @(negedge clk);
            end
        end
        `CHK(n >= 2, 1'b1, "buffer took words")
        k = 0;
        for (int i = 0; i < 2000; i++) begin
            @(negedge clk);
            if (rx_valid === 1'b1) k++;
        end
        `CHK(k, n, "all buffered words sent")
        `CHK(got, 8'h20 + 8'(n - 1), "last word")
        $display("done disable");
    endtask
    task automatic drive_slave(input logic [7:0] d);
        ss_n_i = 1'b0;
        for (int b = 7; b >= 0; b--) begin
            mosi_i = d[b];
            #24 sck_i = 1'b1;
            #24 sck_i = 1'b0;
        end
        #24 ss_n_i = 1'b1;
        mosi_i = ~mosi_i;
    endtask
    task automatic t_slave;
        master_mode = 1'b0;
        pulse(disable_cmd);
        `CHK(enabled, 1'b1, "disable ignored in slave")
        fork
            drive_slave(8'h96);
            wait_rx(400);
        join
        `CHK(rx_data, 8'h96, "slave word")
        pulse(software_reset_bit);
        `CHK(enabled, 1'b0, "soft reset stops")
        master_mode = 1'b1;
        mode_fault_disable = 1'b0;
        pulse(enable_cmd);
        fault_n_i = 1'b0;
        repeat (5) @(negedge clk);
        `CHK(mode_fault, 1'b1, "mode fault raised")
        `CHK(enabled, 1'b0, "mode fault disables")
        fault_n_i = 1'b1;
        pulse(software_reset_bit);
        `CHK(mode_fault, 1'b0, "soft reset clears fault")
        $display("done slave");
    endtask

    initial begin
        {reset_n, enable_cmd, disable_cmd, software_reset_bit} = 4'h0;
        {data_wr, clr, sck_i, mosi_i, cycles} = 0;
        {fail_count, checks_done, tx, cs_sel} = 0;
        {master_mode, mode_fault_disable, fault_n_i, ss_n_i} = 4'hF;
        set_cfg(8'h04, 1'b0, 1'b1);
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        t_reset;
        t_frame;
        t_extra;
        t_stall;
        t_disable;
        t_slave;
        print_verdict;
    end
endmodule
